/* design/prf_timing_pkg.sv */
// Constants, counts and types shared by the burst timing generator
package prf_timing_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int RANGE_W = 12;
    localparam int AZ_W = 12;
    localparam int TRIG_W = 5;
    localparam int ADV_IDX_W = 4;
    localparam int TICK_W = 14;

    // ------------------------------------------------------------
    // Antenna and rate figures
    // ------------------------------------------------------------
    localparam int RANGE_CLK_KHZ = 1300;
    localparam int REV_TIME_MS = 4800;
    localparam int STEPS_PER_REV = 4096;
    localparam int PAIRS_PER_REV = 240;
    localparam int LONG_EVERY = 15;
    localparam int BURST_LEN = 10;
    localparam int ADV_SHORT_INT = 17;
    localparam int ADV_LONG_INT = 18;
    localparam logic [AZ_W-1:0] LAST_STEP = 12'hFFF;
    localparam logic [AZ_W-1:0] STEP_ADV_SHORT = 12'h011;
    localparam logic [AZ_W-1:0] STEP_ADV_LONG = 12'h012;
    localparam logic [ADV_IDX_W-1:0] LONG_ADV_IDX = 4'hE;
    localparam logic [TRIG_W-1:0] TENTH_PRE = 5'h09;
    localparam logic [TRIG_W-1:0] TWENTIETH_PRE = 5'h13;
    localparam logic [TRIG_W-1:0] TRIG_SAT = 5'h14;

    // Range ticks per azimuth step, nominal and fastest antenna
    localparam int NOM_STEP_TICKS_DEF = REV_TIME_MS * RANGE_CLK_KHZ / STEPS_PER_REV;
    localparam int IDLE_TICKS_DEF = 2 * NOM_STEP_TICKS_DEF;
    localparam int MIN_STEP_TICKS_DEF = NOM_STEP_TICKS_DEF * 9 / 10;

    // ------------------------------------------------------------
    // Range counter points (signed counts)
    // ------------------------------------------------------------
    localparam logic signed [RANGE_W-1:0] DTT_NEAR = 12'sh300;
    localparam logic signed [RANGE_W-1:0] DTT_SHIFT = 12'sh008;
    localparam logic signed [RANGE_W-1:0] DTT_FAR = DTT_NEAR + DTT_SHIFT;
    localparam logic signed [RANGE_W-1:0] LOW_COUNTS = 12'sh480;
    localparam logic signed [RANGE_W-1:0] HIGH_COUNTS = 12'sh3A8;
    localparam logic signed [RANGE_W-1:0] AVG_COUNTS = 12'sh410;
    localparam logic signed [RANGE_W-1:0] PRESET_LOW = DTT_NEAR - LOW_COUNTS;
    localparam logic signed [RANGE_W-1:0] PRESET_HIGH = DTT_NEAR - HIGH_COUNTS;
    localparam logic signed [RANGE_W-1:0] PRESET_AVG = DTT_NEAR - AVG_COUNTS;
    localparam logic signed [RANGE_W-1:0] VIDEO_TRIG_POINT = -12'sh00A;
    localparam logic signed [RANGE_W-1:0] ZERO_POINT = 12'sh000;
    localparam logic signed [RANGE_W-1:0] SWEEP_END_POINT = 12'sh2F8;
    localparam logic signed [RANGE_W-1:0] ONE_COUNT = 12'sh001;

    // ------------------------------------------------------------
    // Reload selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_AVG = 2'b00,
        RATE_LOW = 2'b01,
        RATE_HIGH = 2'b10
    } rate_sel_e;

endpackage : prf_timing_pkg

/* design/sync3_pulse.sv */
// Three-stage input synchroniser with agreed level and rising-edge pulse
`timescale 1ns/1ps
module sync3_pulse #(
    parameter int WIDTH = 1
) (
    input wire logic clk_in, // System clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic [WIDTH-1:0] async_in, // Pins from outside the domain
    output logic [WIDTH-1:0] level_out, // Filtered level
    output logic [WIDTH-1:0] rise_out // One-cycle pulse on a rise
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("sync3_pulse needs at least one bit");
    end

    // ------------------------------------------------------------
    // Per-bit chain
    // ------------------------------------------------------------
    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        logic s1_reg;
        logic s2_reg;
        logic s3_reg;
        logic level_reg;
        logic rise_reg;
        logic agree_w;

        // Only stages two and three are compared; stage one may be metastable
        assign agree_w = (s2_reg == s3_reg);

        always_ff @(posedge clk_in or negedge resetn_in)
        begin
            if (!resetn_in)
            begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
                level_reg <= 1'b0;
                rise_reg <= 1'b0;
            end
            else
            begin
                s1_reg <= async_in[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                level_reg <= agree_w ? s3_reg : level_reg;
                rise_reg <= agree_w & s3_reg & ~level_reg;
            end
        end

        assign level_out[i] = level_reg;
        assign rise_out[i] = rise_reg;
    end

endmodule : sync3_pulse

/* design/prf_burst_timing_generator.sv */
// Azimuth-locked pulse repetition timing with low, high and average bursts
//
// Contract
// R1 - Start 240 interval pairs per revolution of 4096 azimuth steps.
// R2 - Triggers come in bursts of ten; two bursts make one pair.
// R3 - Per pair: ten low-rate, ten high-rate, then average-rate triggers.
// R4 - Counts and presets leave at least one average trigger, worst antenna speed.
// R5 - Range counter counts up once per 1.3 MHz range clock.
// R6 - At end of range, reload a negative value and keep counting up.
// R7 - End-of-range point alternates between two values on successive scans.
// R8 - After pair start: low reload ten sweeps, high ten, then average.
// R9 - Step counter increments per azimuth step, clears on north mark.
// R10 - Match pulse when step counter equals target value.
// R11 - Each match advances target by 17; every fifteenth advance is 18.
// R12 - Pair start is video trigger AND azimuth match.
// R13 - Pair start clears the trigger counter counting video triggers.
// R14 - Tenth and twentieth count taps select low, high or average reload.
// R15 - Reload tick position differs by eight counts between scans.
// R16 - Sweep runs from negative preset through zero to sweep end at 760.
// R17 - Internal generator replaces absent azimuth and north pulses.
// R18 - Generated pulses are single cycle, aligned to range clock ticks.
`timescale 1ns/1ps
module prf_burst_timing_generator
    import prf_timing_pkg::*;
#(
    parameter int NOM_STEP_TICKS = NOM_STEP_TICKS_DEF,
    parameter int IDLE_TICKS = IDLE_TICKS_DEF,
    parameter int MIN_STEP_TICKS = MIN_STEP_TICKS_DEF
) (
    input wire logic clk_in, // 100 MHz system clock
    input wire logic resetn_in, // Async reset, active low
    input wire logic azimuth_step_pulse_in, // Antenna step pin
    input wire logic north_mark_pulse_in, // Antenna north pin
    input wire logic range_clk_in, // 1.3 MHz range clock pin
    output logic [RANGE_W-1:0] range_count_out, // Signed range count
    output logic video_trigger_out, // Transmitter trigger pulse
    output logic zero_range_tick_out, // Count reached zero
    output logic sweep_end_tick_out, // Count reached sweep end
    output logic counter_reload_tick_out, // Preset was reloaded
    output logic azimuth_match_out, // Step count met target
    output logic pair_start_pulse_out, // Interval pair begins
    output logic tenth_count_tap_out, // Tenth trigger of pair
    output logic twentieth_count_tap_out, // Twentieth trigger of pair
    output logic [1:0] rate_sel_out, // Reload selection in use
    output logic [AZ_W-1:0] az_step_count_out, // Azimuth step count
    output logic scan_alt_out, // Far reload point selected
    output logic internal_gen_out // Internal step source active
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int BURST_WORST = BURST_LEN * (int'(LOW_COUNTS) + int'(HIGH_COUNTS)
        + 2 * int'(DTT_SHIFT)) + int'(AVG_COUNTS) + int'(DTT_SHIFT);
    localparam int GROUP_STEPS = (LONG_EVERY - 1) * ADV_SHORT_INT + ADV_LONG_INT;

    if (GROUP_STEPS * (PAIRS_PER_REV / LONG_EVERY) != STEPS_PER_REV)
    begin : g_bad_pairs // R1
        $error("advance pattern does not close one revolution");
    end
    if (ADV_SHORT_INT * MIN_STEP_TICKS <= BURST_WORST)
    begin : g_bad_avg // R4
        $error("no room left for an average-rate trigger");
    end
    if (NOM_STEP_TICKS < 2 || NOM_STEP_TICKS >= 2 ** TICK_W)
    begin : g_bad_step
        $error("internal step period out of range");
    end
    if (IDLE_TICKS < 1 || IDLE_TICKS >= 2 ** TICK_W)
    begin : g_bad_idle
        $error("idle timeout out of range");
    end

    localparam logic [TICK_W-1:0] GEN_LAST = TICK_W'(NOM_STEP_TICKS - 1);
    localparam logic [TICK_W-1:0] IDLE_LIM = TICK_W'(IDLE_TICKS);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [2:0] rise_w;
    logic ext_step_w;
    logic ext_north_w;
    logic range_tick_w;
    logic [TICK_W-1:0] idle_reg;
    logic [TICK_W-1:0] gen_reg;
    logic internal_w;
    logic int_step_w;
    logic int_north_w;
    logic step_ev_w;
    logic north_ev_w;
    logic [AZ_W-1:0] az_count_reg;
    logic [AZ_W-1:0] target_reg;
    logic [ADV_IDX_W-1:0] adv_idx_reg;
    logic fresh_reg;
    logic match_w;
    logic match_reg;
    logic pending_reg;
    logic scan_alt_reg;
    logic signed [RANGE_W-1:0] range_count_reg;
    logic signed [RANGE_W-1:0] dtt_point_w;
    logic signed [RANGE_W-1:0] preset_w;
    logic signed [RANGE_W-1:0] range_next;
    logic at_dtt_w;
    logic tick_d_reg;
    logic reload_d_reg;
    logic video_trig_reg;
    logic zero_tick_reg;
    logic sweep_end_reg;
    logic reload_tick_reg;
    logic pair_start_reg;
    logic tenth_reg;
    logic twentieth_reg;
    logic [TRIG_W-1:0] trig_count_reg;
    rate_sel_e rate_reg;
    rate_sel_e rate_next;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    sync3_pulse #(
        .WIDTH(3)
    ) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in({range_clk_in, north_mark_pulse_in, azimuth_step_pulse_in}),
        .level_out(),
        .rise_out(rise_w)
    );

    assign ext_step_w = rise_w[0];
    assign ext_north_w = rise_w[1];
    assign range_tick_w = rise_w[2];

    // ------------------------------------------------------------
    // Internal step generator
    // ------------------------------------------------------------
    // Takes over once no external step arrived for the idle timeout;
    // the first external step hands control straight back
    assign internal_w = (idle_reg == IDLE_LIM);
    assign int_step_w = internal_w & range_tick_w & (gen_reg == GEN_LAST); // R17
    assign int_north_w = int_step_w & (az_count_reg == LAST_STEP); // R17
    assign step_ev_w = ext_step_w | (int_step_w & ~int_north_w);
    assign north_ev_w = ext_north_w | int_north_w;

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            idle_reg <= '0;
            gen_reg <= '0;
        end
        else
        begin
            if (ext_step_w)
                idle_reg <= '0;
            else if (range_tick_w && !internal_w)
                idle_reg <= idle_reg + 1'b1;
            if (!internal_w || int_step_w)
                gen_reg <= '0;
            else if (range_tick_w)
                gen_reg <= gen_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Azimuth step counter and target
    // ------------------------------------------------------------
    // Equality is only judged one cycle after the step count moved, so a
    // match is a single pulse even while the target is being advanced
    assign match_w = fresh_reg & (az_count_reg == target_reg); // R10

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            az_count_reg <= '0;
            fresh_reg <= 1'b0;
            match_reg <= 1'b0;
        end
        else
        begin
            if (north_ev_w)
                az_count_reg <= '0; // R9
            else if (step_ev_w)
                az_count_reg <= az_count_reg + 1'b1; // R9
            fresh_reg <= north_ev_w | step_ev_w;
            match_reg <= match_w;
        end
    end

    // Target restarts at north so the first pair sits on the north mark
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            target_reg <= '0;
            adv_idx_reg <= '0;
        end
        else if (north_ev_w)
        begin
            target_reg <= '0;
            adv_idx_reg <= '0;
        end
        else if (match_w)
        begin
            if (adv_idx_reg == LONG_ADV_IDX)
            begin
                target_reg <= target_reg + STEP_ADV_LONG; // R11 R1
                adv_idx_reg <= '0;
            end
            else
            begin
                target_reg <= target_reg + STEP_ADV_SHORT; // R11 R1
                adv_idx_reg <= adv_idx_reg + 1'b1;
            end
        end
    end

    // Match is held until the next video trigger; a new match wins a clear
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            pending_reg <= 1'b0;
        else if (match_w)
            pending_reg <= 1'b1;
        else if (pair_start_reg)
            pending_reg <= 1'b0;
    end

    // Scan alternation, flipped by every north mark
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            scan_alt_reg <= 1'b0;
        else if (north_ev_w)
            scan_alt_reg <= ~scan_alt_reg; // R7
    end

    // ------------------------------------------------------------
    // Range counter
    // ------------------------------------------------------------
    // Reload one count early so the period equals the interval count
    assign dtt_point_w = scan_alt_reg ? DTT_FAR : DTT_NEAR; // R7 R15
    // At or past the point: a north mark late in a sweep must not skip the reload
    assign at_dtt_w = (range_count_reg >= dtt_point_w - ONE_COUNT);
    assign preset_w = (rate_reg == RATE_LOW) ? PRESET_LOW :
        (rate_reg == RATE_HIGH) ? PRESET_HIGH : PRESET_AVG; // R14
    assign range_next = at_dtt_w ? preset_w : range_count_reg + ONE_COUNT; // R6 R16

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            range_count_reg <= PRESET_AVG;
        else if (range_tick_w)
            range_count_reg <= range_next; // R5
    end

    // ------------------------------------------------------------
    // Sweep decodes
    // ------------------------------------------------------------
    // All decodes land two cycles after the range tick, one pulse each
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            tick_d_reg <= 1'b0;
            reload_d_reg <= 1'b0;
            video_trig_reg <= 1'b0;
            zero_tick_reg <= 1'b0;
            sweep_end_reg <= 1'b0;
            reload_tick_reg <= 1'b0;
            pair_start_reg <= 1'b0;
        end
        else
        begin
            tick_d_reg <= range_tick_w;
            reload_d_reg <= range_tick_w & at_dtt_w;
            video_trig_reg <= tick_d_reg & (range_count_reg == VIDEO_TRIG_POINT); // R18
            zero_tick_reg <= tick_d_reg & (range_count_reg == ZERO_POINT); // R18
            sweep_end_reg <= tick_d_reg & (range_count_reg == SWEEP_END_POINT); // R16
            reload_tick_reg <= reload_d_reg; // R15
            pair_start_reg <= tick_d_reg & (range_count_reg == VIDEO_TRIG_POINT)
                & pending_reg; // R12
        end
    end

    // ------------------------------------------------------------
    // Trigger counter and burst selection
    // ------------------------------------------------------------
    // Saturates at twenty so long average stretches cannot wrap into a tap
    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            trig_count_reg <= TRIG_SAT;
            tenth_reg <= 1'b0;
            twentieth_reg <= 1'b0;
        end
        else
        begin
            if (pair_start_reg)
                trig_count_reg <= '0; // R13
            else if (video_trig_reg && trig_count_reg != TRIG_SAT)
                trig_count_reg <= trig_count_reg + 1'b1; // R13
            tenth_reg <= video_trig_reg & ~pair_start_reg
                & (trig_count_reg == TENTH_PRE); // R14
            twentieth_reg <= video_trig_reg & ~pair_start_reg
                & (trig_count_reg == TWENTIETH_PRE); // R14
        end
    end

    // Low, then high, then average reloads for each pair
    always_comb
    begin
        rate_next = rate_reg;
        unique case (rate_reg)
            RATE_AVG:
                if (pair_start_reg)
                    rate_next = RATE_LOW; // R8 R2
            RATE_LOW:
                if (pair_start_reg)
                    rate_next = RATE_LOW;
                else if (tenth_reg)
                    rate_next = RATE_HIGH; // R3
            RATE_HIGH:
                if (pair_start_reg)
                    rate_next = RATE_LOW;
                else if (twentieth_reg)
                    rate_next = RATE_AVG; // R3
            default:
                rate_next = RATE_AVG;
        endcase
    end

    always_ff @(posedge clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
            rate_reg <= RATE_AVG;
        else
            rate_reg <= rate_next;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign range_count_out = range_count_reg;
    assign video_trigger_out = video_trig_reg;
    assign zero_range_tick_out = zero_tick_reg;
    assign sweep_end_tick_out = sweep_end_reg;
    assign counter_reload_tick_out = reload_tick_reg;
    assign azimuth_match_out = match_reg;
    assign pair_start_pulse_out = pair_start_reg;
    assign tenth_count_tap_out = tenth_reg;
    assign twentieth_count_tap_out = twentieth_reg;
    assign rate_sel_out = rate_reg;
    assign az_step_count_out = az_count_reg;
    assign scan_alt_out = scan_alt_reg;
    assign internal_gen_out = internal_w;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);

    AST_RANGE_STEP: assert property ( // R5
        range_tick_w && !at_dtt_w |=> range_count_reg == $past(range_count_reg) + ONE_COUNT)
        else $error("range counter did not advance");
    AST_RELOAD: assert property ( // R6
        range_tick_w && at_dtt_w |=> range_count_reg == $past(preset_w) && range_count_reg < 0)
        else $error("range counter did not reload a negative preset");
    AST_SCAN_ALT: assert property ( // R7
        north_ev_w |=> scan_alt_reg != $past(scan_alt_reg))
        else $error("scan alternation missed a north mark");
    AST_LOW_FIRST: assert property ( // R8
        pair_start_reg |=> rate_reg == RATE_LOW && trig_count_reg == '0)
        else $error("pair start did not select the low rate");
    AST_AZ_CLEAR: assert property ( // R9
        north_ev_w |=> az_count_reg == '0 ##1 match_reg)
        else $error("north mark did not clear and match the step count");
    AST_AZ_INC: assert property ( // R9
        step_ev_w && !north_ev_w |=> az_count_reg == $past(az_count_reg) + 1'b1)
        else $error("step counter did not increment");
    AST_ADVANCE: assert property ( // R11
        match_w && !north_ev_w |=> (target_reg - $past(target_reg) == STEP_ADV_SHORT)
            || (target_reg - $past(target_reg) == STEP_ADV_LONG))
        else $error("target advanced by a wrong amount");
    AST_PAIR_AND: assert property ( // R12
        pair_start_reg |-> video_trig_reg && $past(pending_reg))
        else $error("pair start without trigger and match");
    AST_TENTH_HIGH: assert property ( // R14
        tenth_reg && !pair_start_reg |-> trig_count_reg == TENTH_PRE + 1'b1
            ##1 rate_reg == RATE_HIGH)
        else $error("tenth tap did not select the high rate");
    AST_SWEEP_END: assert property ( // R16
        sweep_end_reg |-> range_count_reg == SWEEP_END_POINT && !zero_tick_reg)
        else $error("sweep end tick at a wrong count");
    AST_SINGLE_PULSE: assert property ( // R18
        pair_start_reg || video_trig_reg |=> !pair_start_reg && !video_trig_reg)
        else $error("trigger pulse longer than one cycle");
    AST_INTERNAL: assert property ( // R17
        int_step_w && !int_north_w |=> az_count_reg == $past(az_count_reg) + 1'b1)
        else $error("internal generator step lost");

    COV_PAIR: cover property (pair_start_reg ##[1:1000] tenth_reg);
    COV_TWENTIETH: cover property (twentieth_reg);
    COV_INTERNAL: cover property (int_step_w);
    COV_SCAN: cover property (north_ev_w && scan_alt_reg);

endmodule : prf_burst_timing_generator

/* test/antenna_model.sv */
// Antenna encoder pins and free-running range clock for the timing bench
`timescale 1ns/1ps
module antenna_model (
    input wire logic clk_in, // System clock
    input wire logic step_go_in, // Ask for one step
    input wire logic north_go_in, // Ask for one north mark
    output logic step_out, // Step pin
    output logic north_out, // North pin
    output logic rclk_out // Range clock pin
);
    logic [2:0] div_reg = 3'h0;
    logic [2:0] sw_reg = 3'h0;
    logic [2:0] nw_reg = 3'h0;
    // Pins held five cycles so the input filter keeps them
    always_ff @(posedge clk_in)
    begin
        div_reg <= div_reg + 3'h1;
        sw_reg <= step_go_in ? 3'h5 : sw_reg - 3'(sw_reg != 3'h0);
        nw_reg <= north_go_in ? 3'h5 : nw_reg - 3'(nw_reg != 3'h0);
    end
    // Eight cycles a tick keeps the run short; four high, four low
    assign rclk_out = div_reg[2];
    assign step_out = (sw_reg != 3'h0);
    assign north_out = (nw_reg != 3'h0);
endmodule : antenna_model

/* test/prf_burst_timing_generator_test.sv */
// Self-checking bench for the burst timing generator
`timescale 1ns/1ps
module prf_burst_timing_generator_test import prf_timing_pkg::*;;
    typedef struct {int n; logic [11:0] cnt; logic [11:0] m;} row_s;
    row_s rows [5] = '{'{16, 12'h010, 12'h000}, '{1, 12'h011, 12'h001},
        '{17, 12'h022, 12'h002}, '{221, 12'h0FF, 12'h00E}, '{1, 12'h100, 12'h00F}};
    logic clk_in = 1'b0, resetn_in = 1'b0, step_go = 1'b0, north_go = 1'b0;
    logic step_w, north_w, rclk_w, reload_w, match_w, start_w, alt_w, int_w, vtrig_w;
    logic [11:0] range_w, az_w;
    logic [1:0] rate_w;
    int error_cnt = 0, n_compared = 0, cyc = 0, mcnt = 0, pcnt = 0, vcnt = 0, ticks;
    time t0;
    antenna_model pm (.clk_in(clk_in), .step_go_in(step_go), .north_go_in(north_go),
        .step_out(step_w), .north_out(north_w), .rclk_out(rclk_w));
    // Short internal generator counts; idle kept long so it stays out of the way
    prf_burst_timing_generator #(.NOM_STEP_TICKS(8), .IDLE_TICKS(3000)) dut (
        .clk_in(clk_in), .resetn_in(resetn_in), .azimuth_step_pulse_in(step_w),
        .north_mark_pulse_in(north_w), .range_clk_in(rclk_w), .range_count_out(range_w),
        .video_trigger_out(vtrig_w), .zero_range_tick_out(), .sweep_end_tick_out(),
        .counter_reload_tick_out(reload_w), .azimuth_match_out(match_w),
        .pair_start_pulse_out(start_w), .tenth_count_tap_out(), .twentieth_count_tap_out(),
        .rate_sel_out(rate_w), .az_step_count_out(az_w), .scan_alt_out(alt_w),
        .internal_gen_out(int_w));
    initial forever #5 clk_in = ~clk_in;
    // Pulse counters and hang guard
    always @(negedge clk_in)
    begin
        mcnt += int'(match_w === 1'b1);
        pcnt += int'(start_w === 1'b1);
        vcnt += int'(vtrig_w === 1'b1);
    end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 70000)
        begin
            error_cnt++;
            results();
        end
    end
    task chk(input logic [11:0] got, input logic [11:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : chk
    task pulse(input int n, input logic nm);
        repeat (n)
        begin
            @(posedge clk_in);
            step_go <= ~nm;
            north_go <= nm;
            @(posedge clk_in);
            step_go <= 1'b0;
            north_go <= 1'b0;
            repeat (10) @(posedge clk_in);
        end
    endtask : pulse
    // Next reload pulse, bounded; ticks holds the sweep length since the last one
    task wait_rl;
        int k;
        k = 0;
        @(negedge clk_in);
        while (reload_w !== 1'b1 && k < 12000)
        begin
            @(negedge clk_in);
            k++;
        end
        chk(12'(k < 12000), 12'h001);
        ticks = int'(($time - t0) / 80);
        t0 = $time;
    endtask : wait_rl
    task results;
        $display("Compared %0d, mismatched %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results
    initial
    begin
        repeat (10) @(posedge clk_in);
        chk(range_w, 12'hEF0);
        chk(12'(rate_w), 12'h000);
        chk(az_w, 12'h000);
        resetn_in <= 1'b1;
        $display("Test reset done");
        // Match at step 0 arms the first pair; two marks leave the near point
        pulse(2, 1'b1);
        wait_rl();
        chk(12'(rate_w), 12'h001);
        chk(12'(pcnt), 12'h001);
        wait_rl();
        chk(12'(ticks), 12'd1152);
        chk(12'(vcnt), 12'h002);
        $display("Test low burst done");
        mcnt = 0;
        foreach (rows[i])
        begin
            pulse(rows[i].n, 1'b0);
            chk(az_w, rows[i].cnt);
            chk(12'(mcnt), rows[i].m);
        end
        $display("Test azimuth steps done");
        pulse(1, 1'b0 + 1'b1);
        chk(az_w, 12'h000);
        chk(12'(alt_w), 12'h001);
        wait_rl();
        wait_rl();
        chk(12'(ticks), 12'd1160);
        $display("Test scan jitter done");
        while (int_w !== 1'b1 && cyc < 60000)
            @(negedge clk_in);
        chk(12'(int_w), 12'h001);
        chk(az_w, 12'h000);
        repeat (400) @(negedge clk_in);
        chk(12'(az_w != 12'h000), 12'h001);
        pulse(1, 1'b0);
        chk(12'(int_w), 12'h000);
        $display("Test internal source done");
        // Mid-run reset must restore counts and the scan choice
        resetn_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        chk(range_w, 12'hEF0);
        chk(12'(alt_w), 12'h000);
        chk(az_w, 12'h000);
        resetn_in <= 1'b1;
        $display("Test mid-run reset done");
        results();
    end
endmodule : prf_burst_timing_generator_test
